// ==== hw/hat_pkg.sv ====
// Shared constants and types for the hall auto-tuning and compensation block
package hat_pkg;

  // ==========================================================
  // Register map (byte-wide registers on the host register port)
  localparam logic [7:0] ADDR_SYSTEM_FLAGS     = 8'h10;
  localparam logic [7:0] ADDR_INDIRECT_SEL     = 8'hf0;
  localparam logic [7:0] ADDR_INDIRECT_DATA    = 8'hf1;
  localparam int         FLAG_TUNE_BUSY_BIT    = 2;     // Tuning busy bit in system flags
  localparam logic [7:0] SEL_SAVED_COMP_FIRST  = 8'hd4; // Low byte of the constant
  localparam logic [7:0] SEL_SAVED_COMP_SECOND = 8'hd5; // High byte of the constant
  localparam logic [7:0] SELECTOR_RESET        = 8'h00;

  // ==========================================================
  // Arithmetic formats
  localparam int          COUNT_W    = 16;              // Raw channel count width
  localparam int          RECIP_W    = 20;              // Reciprocal width
  localparam int          DIV_W      = 40;              // Divider operand width
  localparam int          KAPPA_W    = 16;              // Constant, 8 integer . 8 fraction
  localparam int          KAPPA_FRAC = 8;
  localparam logic [15:0] KAPPA_ONE  = 16'h0100;        // Unity at start-up
  localparam logic [39:0] RECIP_ONE  = 40'h0000100000;  // Numerator of 2^20 / count

  // ==========================================================
  // Tuning field widths
  localparam int COARSE_W = 4;
  localparam int FINE_W   = 4;
  localparam int COMP_W   = 10;

  // Four raw channel counts, untouched by compensation
  typedef struct packed {
    logic [COUNT_W-1:0] plate2InvertedChan;
    logic [COUNT_W-1:0] plate2NormalChan;
    logic [COUNT_W-1:0] plate1InvertedChan;
    logic [COUNT_W-1:0] plate1NormalChan;
  } hat_chan_t;

  // Per-plate base and target counts
  typedef struct packed {
    logic [COUNT_W-1:0] baseCount;
    logic [COUNT_W-1:0] targetCount;
  } hat_cfg_t;

  // Per-plate front-end settings chosen by tuning
  typedef struct packed {
    logic [COARSE_W-1:0] coarse;
    logic [FINE_W-1:0]   fine;
    logic [COMP_W-1:0]   comp;
  } hat_tune_t;

endpackage : hat_pkg

// ==== hw/hat_serial_div.sv ====
// Restoring serial divider, one quotient bit per clock
`timescale 1ns/1ps
module hat_serial_div #(
  parameter int W = 40
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output logic              done,
  output logic [W-1:0]      quot
);

  // ==========================================================
  // Elaboration check
  if (W < 4 || W > 64) begin : g_bad_w
    $error("hat_serial_div: W out of range");
  end

  localparam int         DIV_WAIT = W;           // Edges after the two quiet ones until done
  localparam logic [6:0] CNT_W   = 7'(W);

  logic [W-1:0] rem_ff;                           // Partial remainder
  logic [6:0]   cnt_ff;                           // Bits still to produce
  logic         busy_ff;                          // Iterating
  logic [W:0]   shifted;                          // Remainder with next bit in

  assign shifted = {rem_ff, quot[W-1]};

  // ==========================================================
  // Iteration; a zero divisor yields all ones, which callers treat as saturated
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rem_ff  <= '0;
      quot    <= '0;
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_ff  <= '0;
        quot    <= num;
        cnt_ff  <= CNT_W;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (shifted >= {1'b0, den}) begin
          rem_ff <= W'(shifted - {1'b0, den});
          quot   <= {quot[W-2:0], 1'b1};
        end else begin
          rem_ff <= shifted[W-1:0];
          quot   <= {quot[W-2:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 7'h01;
        if (cnt_ff == 7'h01) begin
          busy_ff <= 1'b0;
          done    <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Fixed latency check; the caller still waits for done before each next reciprocal, constant or ratio
  property p_div_latency;
    @(posedge ref_clk) disable iff (!rstn)
      start |-> !done [*2] ##[DIV_WAIT:DIV_WAIT] done;
  endproperty
  a_div_latency: assert property (p_div_latency) else $error("divider latency wrong");

endmodule : hat_serial_div

// ==== hw/hat_compensation.sv ====
// Hall plate auto-tuning, reference checks and on-chip amplitude compensation
`timescale 1ns/1ps

// How it works
// - Tune each plate from a normal/inverted channel pair.
// - Reference is one over twice the reciprocal sum.
// - Tuning sets coarse, fine, comp from base, target.
// - Phase one: comp zero, multipliers reach base.
// - Phase two: step comp until target reached.
// - Compensation only in angle path, raw untouched.
// - Track top-term crossings and extremes of both terms.
// - Top, bottom terms from reciprocals; ratio top/bottom.
// - Constant is max bottom over max top; scales ratio.
// - Update constant only after both extremes seen.
// - Constant starts at one; rotation needed afterwards.
// - Plate one uses channels two/three, two four/five.
module hat_compensation (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire hat_pkg::hat_chan_t chanCounts,      // Raw counts from the front end
  input  wire logic               sampleValid,     // New counts this cycle
  input  wire logic               tuneStart,       // Begin auto-tuning of both plates
  input  wire hat_pkg::hat_cfg_t  plateCfg [2],    // Base and target per plate
  input  wire logic               regWrEn,
  input  wire logic               regRdEn,
  input  wire logic [7:0]         regAddr,
  input  wire logic [7:0]         regWrData,
  output logic [7:0]              regRdData,
  output hat_pkg::hat_tune_t      tuneSettings [2],
  output logic [hat_pkg::DIV_W:0] angleRatio,      // Sign and magnitude, 8 fraction bits
  output logic                    ratioValid
);

  localparam int RW = hat_pkg::RECIP_W;
  localparam int DW = hat_pkg::DIV_W;

  // ==========================================================
  // Tuning state per plate
  typedef enum logic [1:0] {TUNE_IDLE, TUNE_MULT, TUNE_COMP, TUNE_DONE} hat_tune_state_t;
  hat_tune_state_t               tuneState_ff [2];
  logic [1:0]                    plateBusy;
  logic [hat_pkg::COUNT_W-1:0]   normalCnt [2];     // Non-inverted channel per plate
  logic [hat_pkg::COUNT_W-1:0]   invertCnt [2];     // Inverted channel per plate

  assign normalCnt[0] = chanCounts.plate1NormalChan;
  assign invertCnt[0] = chanCounts.plate1InvertedChan;
  assign normalCnt[1] = chanCounts.plate2NormalChan;
  assign invertCnt[1] = chanCounts.plate2InvertedChan;

  // Reference at least x, without a divide: a*b >= 2*x*(a+b)
  function automatic logic refAtLeast(input logic [15:0] a, input logic [15:0] b,
                                      input logic [15:0] x);
    logic [33:0] prod;
    logic [33:0] bound;
    prod  = {2'b00, 32'(a) * 32'(b)};                  // Full product, no wrap
    bound = 34'({x, 1'b0}) * 34'({1'b0, a} + {1'b0, b});
    return prod >= bound;
  endfunction : refAtLeast

  for (genvar p = 0; p < 2; p++) begin : g_plate
    logic refBase;
    logic refTarget;
    assign refBase   = refAtLeast(normalCnt[p], invertCnt[p], plateCfg[p].baseCount);
    assign refTarget = refAtLeast(normalCnt[p], invertCnt[p], plateCfg[p].targetCount);
    assign plateBusy[p] = (tuneState_ff[p] == TUNE_MULT) || (tuneState_ff[p] == TUNE_COMP);

    // Multipliers first with comp held at zero, then comp; one step per sample
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        tuneState_ff[p] <= TUNE_IDLE;
        tuneSettings[p] <= '0;
      end else if (tuneStart) begin
        tuneState_ff[p] <= TUNE_MULT;
        tuneSettings[p] <= '0;
      end else if (sampleValid) begin
        case (tuneState_ff[p])
          TUNE_MULT: begin
            // Fine steps, carrying into coarse; full scale gives up and moves on
            if (!refBase && !(&{tuneSettings[p].coarse, tuneSettings[p].fine})) begin
              {tuneSettings[p].coarse, tuneSettings[p].fine} <=
                {tuneSettings[p].coarse, tuneSettings[p].fine} + 8'h01;
            end else begin
              tuneState_ff[p] <= TUNE_COMP;
            end
          end
          TUNE_COMP: begin
            if (!refTarget && !(&tuneSettings[p].comp)) begin
              tuneSettings[p].comp <= tuneSettings[p].comp + 10'h001;
            end else begin
              tuneState_ff[p] <= TUNE_DONE;
            end
          end
          default: begin
            tuneState_ff[p] <= tuneState_ff[p];
          end
        endcase
      end
    end

    property p_comp_zero;
      @(posedge ref_clk) disable iff (!rstn)
        tuneState_ff[p] == TUNE_MULT |-> tuneSettings[p].comp == 10'h000;
    endproperty
    a_comp_zero: assert property (p_comp_zero) else $error("comp not zero in phase one");

    property p_comp_step;
      @(posedge ref_clk) disable iff (!rstn)
        (tuneState_ff[p] == TUNE_COMP && sampleValid && !tuneStart && !refTarget
         && !(&tuneSettings[p].comp))
        |=> tuneSettings[p].comp == $past(tuneSettings[p].comp) + 10'h001;
    endproperty
    a_comp_step: assert property (p_comp_step) else $error("comp did not step");

    property p_mult_hold;
      @(posedge ref_clk) disable iff (!rstn)
        (tuneState_ff[p] == TUNE_MULT && sampleValid && !tuneStart && refBase)
        |=> $stable(tuneSettings[p].fine) ##0 tuneState_ff[p] == TUNE_COMP;
    endproperty
    a_mult_hold: assert property (p_mult_hold) else $error("multiplier overshoot");
  end

  // ==========================================================
  // Angle path: reciprocals, terms, constant and ratio
  typedef enum logic [2:0] {PROC_IDLE, PROC_RECIP, PROC_TERMS, PROC_KAPPA,
                            PROC_RATIO} hat_proc_state_t;
  hat_proc_state_t           procState_ff;
  hat_pkg::hat_chan_t        chanLatch_ff;          // Private copy; raw inputs never altered
  logic [1:0]                recIdx_ff;
  logic [RW-1:0]             recip_ff [4];          // Order: ch2, ch3, ch4, ch5
  logic [hat_pkg::COUNT_W-1:0] chanPick;
  logic                      divStart_ff;
  logic [DW-1:0]             divNum_ff;
  logic [DW-1:0]             divDen_ff;
  logic                      divDone;
  logic [DW-1:0]             divQuot;
  logic signed [RW:0]        termTop;
  logic signed [RW:0]        termBot;
  logic [RW-1:0]             absTop;
  logic [RW-1:0]             absBot;
  logic [RW-1:0]             segMaxTop_ff;          // Largest magnitude this half turn
  logic [RW-1:0]             segMaxBot_ff;
  logic                      peakTop_ff;            // Extreme passed this half turn
  logic                      peakBot_ff;
  logic                      signTop_ff;
  logic                      crossing;
  logic                      kappaUpdate;
  logic                      ratioNeg_ff;
  logic [hat_pkg::KAPPA_W-1:0] kappa_ff;
  logic [7:0]                selector_ff;           // Indirect location chosen by the host

  // Next channel to invert; wraps harmlessly after the last one
  assign chanPick = chanLatch_ff[hat_pkg::COUNT_W*2'(recIdx_ff + 2'h1) +: hat_pkg::COUNT_W];
  assign termTop  = $signed({1'b0, recip_ff[2]}) - $signed({1'b0, recip_ff[0]});
  assign termBot  = $signed({1'b0, recip_ff[3]}) - $signed({1'b0, recip_ff[1]});
  assign absTop   = termTop[RW] ? RW'(-termTop) : termTop[RW-1:0];
  assign absBot   = termBot[RW] ? RW'(-termBot) : termBot[RW-1:0];
  assign crossing = termTop[RW] != signTop_ff;     // Sign flip of top term: 0 or 180 deg
  assign kappaUpdate = crossing && peakTop_ff && peakBot_ff;

  hat_serial_div #(.W(DW)) u_div (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (divStart_ff),
    .num     (divNum_ff),
    .den     (divDen_ff),
    .done    (divDone),
    .quot    (divQuot)
  );

  // Sequencer; samples that arrive while busy are skipped, not queued
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      procState_ff <= PROC_IDLE;
      chanLatch_ff <= '0;
      recIdx_ff    <= '0;
      divStart_ff  <= 1'b0;
      divNum_ff    <= '0;
      divDen_ff    <= '0;
      ratioNeg_ff  <= 1'b0;
      angleRatio   <= '0;
      ratioValid   <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        recip_ff[i] <= '0;
      end
    end else begin
      divStart_ff <= 1'b0;
      ratioValid  <= 1'b0;
      case (procState_ff)
        PROC_IDLE: begin
          if (sampleValid) begin
            chanLatch_ff <= chanCounts;
            divNum_ff    <= hat_pkg::RECIP_ONE;
            divDen_ff    <= DW'(chanCounts.plate1NormalChan);
            divStart_ff  <= 1'b1;
            recIdx_ff    <= '0;
            procState_ff <= PROC_RECIP;
          end
        end
        PROC_RECIP: begin
          if (divDone) begin
            recip_ff[recIdx_ff] <= (|divQuot[DW-1:RW]) ? '1 : divQuot[RW-1:0];
            if (recIdx_ff == 2'h3) begin
              procState_ff <= PROC_TERMS;
            end else begin
              recIdx_ff   <= recIdx_ff + 2'h1;
              divDen_ff   <= DW'(chanPick);
              divStart_ff <= 1'b1;
            end
          end
        end
        PROC_TERMS: begin
          divStart_ff <= 1'b1;
          ratioNeg_ff <= termTop[RW] ^ termBot[RW];
          if (kappaUpdate) begin
            divNum_ff    <= DW'({segMaxBot_ff, 8'h00});
            divDen_ff    <= DW'(segMaxTop_ff);
            procState_ff <= PROC_KAPPA;
          end else begin
            divNum_ff    <= DW'(absTop) * DW'(kappa_ff);
            divDen_ff    <= DW'(absBot);
            procState_ff <= PROC_RATIO;
          end
        end
        PROC_KAPPA: begin
          if (divDone) begin
            divNum_ff    <= DW'(absTop) * DW'(divQuot[hat_pkg::KAPPA_W-1:0]);
            divDen_ff    <= DW'(absBot);
            divStart_ff  <= 1'b1;
            procState_ff <= PROC_RATIO;
          end
        end
        default: begin
          if (divDone) begin
            angleRatio   <= {ratioNeg_ff, divQuot};
            ratioValid   <= 1'b1;
            procState_ff <= PROC_IDLE;
          end
        end
      endcase
    end
  end

  // Half-turn trackers: magnitude peaks and whether each peak was passed
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      segMaxTop_ff <= '0;
      segMaxBot_ff <= '0;
      peakTop_ff   <= 1'b0;
      peakBot_ff   <= 1'b0;
      signTop_ff   <= 1'b0;
    end else if (procState_ff == PROC_TERMS) begin
      signTop_ff <= termTop[RW];
      if (crossing) begin
        segMaxTop_ff <= absTop;
        segMaxBot_ff <= absBot;
        peakTop_ff   <= 1'b0;
        peakBot_ff   <= 1'b0;
      end else begin
        segMaxTop_ff <= (absTop > segMaxTop_ff) ? absTop : segMaxTop_ff;
        segMaxBot_ff <= (absBot > segMaxBot_ff) ? absBot : segMaxBot_ff;
        peakTop_ff   <= peakTop_ff | (absTop < segMaxTop_ff);
        peakBot_ff   <= peakBot_ff | (absBot < segMaxBot_ff);
      end
    end
  end

  // ==========================================================
  // Compensation constant: unity at reset, host restore, rotation update
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      kappa_ff <= hat_pkg::KAPPA_ONE;
    end else if (regWrEn && regAddr == hat_pkg::ADDR_INDIRECT_DATA
                 && selector_ff == hat_pkg::SEL_SAVED_COMP_FIRST) begin
      kappa_ff[7:0] <= regWrData;
    end else if (regWrEn && regAddr == hat_pkg::ADDR_INDIRECT_DATA
                 && selector_ff == hat_pkg::SEL_SAVED_COMP_SECOND) begin
      kappa_ff[15:8] <= regWrData;
    end else if (procState_ff == PROC_KAPPA && divDone) begin
      kappa_ff <= (|divQuot[DW-1:hat_pkg::KAPPA_W]) ? '1 : divQuot[hat_pkg::KAPPA_W-1:0];
    end
  end

  // ==========================================================
  // Host registers
  logic [7:0] sysFlags;
  logic [7:0] indirectRead;

  always_comb begin
    sysFlags = '0;
    sysFlags[hat_pkg::FLAG_TUNE_BUSY_BIT] = |plateBusy;
  end

  // Unknown selector codes read as zero and swallow writes
  always_comb begin
    if (selector_ff == hat_pkg::SEL_SAVED_COMP_FIRST) begin
      indirectRead = kappa_ff[7:0];
    end else if (selector_ff == hat_pkg::SEL_SAVED_COMP_SECOND) begin
      indirectRead = kappa_ff[15:8];
    end else begin
      indirectRead = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      selector_ff <= hat_pkg::SELECTOR_RESET;
    end else if (regWrEn && regAddr == hat_pkg::ADDR_INDIRECT_SEL) begin
      selector_ff <= regWrData;
    end
  end

  // Read data registered one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      if (regAddr == hat_pkg::ADDR_SYSTEM_FLAGS) begin
        regRdData <= sysFlags;
      end else if (regAddr == hat_pkg::ADDR_INDIRECT_SEL) begin
        regRdData <= selector_ff;
      end else if (regAddr == hat_pkg::ADDR_INDIRECT_DATA) begin
        regRdData <= indirectRead;
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Checks
  property p_busy_read;
    @(posedge ref_clk) disable iff (!rstn)
      regRdEn && regAddr == hat_pkg::ADDR_SYSTEM_FLAGS
      |=> regRdData[hat_pkg::FLAG_TUNE_BUSY_BIT] == $past(|plateBusy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy flag misreported");

  property p_restore_low;
    @(posedge ref_clk) disable iff (!rstn)
      regWrEn && regAddr == hat_pkg::ADDR_INDIRECT_DATA
      && selector_ff == hat_pkg::SEL_SAVED_COMP_FIRST
      |=> kappa_ff[7:0] == $past(regWrData);
  endproperty
  a_restore_low: assert property (p_restore_low) else $error("restore lost");

  property p_kappa_cause;
    @(posedge ref_clk) disable iff (!rstn)
      !$stable(kappa_ff) |-> $past(regWrEn) || $past(procState_ff == PROC_KAPPA);
  endproperty
  a_kappa_cause: assert property (p_kappa_cause) else $error("constant changed unasked");

  property p_ratio_valid;
    @(posedge ref_clk) disable iff (!rstn)
      ratioValid |-> $past(procState_ff == PROC_RATIO) && procState_ff == PROC_IDLE;
  endproperty
  a_ratio_valid: assert property (p_ratio_valid) else $error("ratio out of sequence");

endmodule : hat_compensation

// ==== tb/hat_host_model.sv ====
// Host controller model that drives the byte-wide register port
`timescale 1ns/1ps
module hat_host_model (
  input  wire logic       ref_clk,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData
);
  // ==========================================================
  // Idle state: lines start quiet
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // One write; released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(posedge ref_clk);
    #2;
    regWrEn   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask : wr

  // One read; data is taken a cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #2;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge ref_clk);
    #2;
    regRdEn = 1'b0;
    regAddr = ~a;
    d       = regRdData;
  endtask : rd

  // Selector first, data register in a separate access
  task automatic rd_ind(input logic [7:0] sel, output logic [7:0] d);
    wr(hat_pkg::ADDR_INDIRECT_SEL, sel);
    rd(hat_pkg::ADDR_INDIRECT_DATA, d);
  endtask : rd_ind

  // Restore pairs a selector code with its saved value back to back
  task automatic wr_ind(input logic [7:0] sel, input logic [7:0] d);
    wr(hat_pkg::ADDR_INDIRECT_SEL, sel);
    wr(hat_pkg::ADDR_INDIRECT_DATA, d);
  endtask : wr_ind
endmodule : hat_host_model

// ==== tb/hat_compensation_tb.sv ====
// Self-checking bench for the hall tuning and compensation block
`timescale 1ns/1ps
module hat_compensation_tb;
  // ==========================================================
  // Signals
  logic               ref_clk = 1'b0;    // 40 MHz
  logic               rstn    = 1'b0;    // Async, active low
  hat_pkg::hat_chan_t chanCounts = '0;   // Front-end counts
  logic               sampleValid = 1'b0;
  logic               tuneStart   = 1'b0;
  hat_pkg::hat_cfg_t  plateCfg [2];      // Base and target per plate
  logic               regWrEn, regRdEn;
  logic [7:0]         regAddr, regWrData, regRdData;
  hat_pkg::hat_tune_t tuneSettings [2];
  logic [40:0]        angleRatio;
  logic               ratioValid;
  int                 errors = 0;        // Mismatch count
  int                 nTests = 0;        // Comparison count
  int                 cycles = 0;        // Hang guard
  logic [7:0]         d;

  always #12.5 ref_clk = ~ref_clk;

  // ==========================================================
  // Instances
  hat_compensation DUT (.ref_clk(ref_clk), .rstn(rstn), .chanCounts(chanCounts),
    .sampleValid(sampleValid), .tuneStart(tuneStart), .plateCfg(plateCfg),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .tuneSettings(tuneSettings), .angleRatio(angleRatio),
    .ratioValid(ratioValid));
  hat_host_model host (.ref_clk(ref_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", errors, nTests);
    if (errors == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Whole run needs under two thousand cycles; far above that means a hang
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  // ==========================================================
  // Stimulus helpers
  task automatic sample(input logic [15:0] c2, c3, c4, c5);
    @(posedge ref_clk);
    #2;
    chanCounts  = {c5, c4, c3, c2};
    sampleValid = 1'b1;
    @(posedge ref_clk);
    #2;
    sampleValid = 1'b0;
  endtask : sample

  // Angle result: bounded wait for the one-cycle valid pulse
  task automatic angle(input logic [15:0] c2, c3, c4, c5, input logic [40:0] exp);
    sample(c2, c3, c4, c5);
    repeat (400) begin
      @(posedge ref_clk);
      #1;
      if (ratioValid === 1'b1) break;
    end
    chk(ratioValid, 1'b1);
    if (exp[40] === 1'bx) chk(angleRatio[39:0], exp[39:0]);
    else chk(angleRatio, exp);
  endtask : angle

  // One tuning step applied to both plates
  task automatic tune_step(input logic [15:0] p, input logic [17:0] exp);
    sample(p, p, p, p);
    repeat (2) @(posedge ref_clk);
    chk(tuneSettings[0], exp);
    chk(tuneSettings[1], exp);
  endtask : tune_step

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    host.rd(hat_pkg::ADDR_SYSTEM_FLAGS, d);
    chk(d, 8'h00);
    host.rd(8'h55, d);
    chk(d, 8'h00);
    host.rd_ind(hat_pkg::SEL_SAVED_COMP_FIRST, d);
    chk(d, 8'h00);
    host.rd_ind(hat_pkg::SEL_SAVED_COMP_SECOND, d);
    chk(d, 8'h01);
  endtask : t_reset

  // Reciprocals 1024/512 and 512/256 give a ratio of two at unity constant
  task automatic t_angle();
    angle(16'h0800, 16'h1000, 16'h0400, 16'h0800, 41'h00000000200);
    angle(16'h0400, 16'h1000, 16'h0800, 16'h0800, 41'h10000000200);
    angle(16'h0800, 16'h0800, 16'h0400, 16'h0800, {1'bx, 40'hffffffffff});
    host.rd_ind(hat_pkg::SEL_SAVED_COMP_SECOND, d);
    chk(d, 8'h01);
  endtask : t_angle

  // References 50, 100, 100, 150 against base 100 and target 150
  task automatic t_tune();
    plateCfg[0] = {16'h0064, 16'h0096};
    plateCfg[1] = {16'h0064, 16'h0096};
    @(posedge ref_clk);
    #2;
    tuneStart = 1'b1;
    @(posedge ref_clk);
    #2;
    tuneStart = 1'b0;
    host.rd(hat_pkg::ADDR_SYSTEM_FLAGS, d);
    chk(d, 8'h04);
    tune_step(16'd200, {4'h0, 4'h1, 10'h000});
    tune_step(16'd400, {4'h0, 4'h1, 10'h000});
    tune_step(16'd400, {4'h0, 4'h1, 10'h001});
    tune_step(16'd600, {4'h0, 4'h1, 10'h001});
    host.rd(hat_pkg::ADDR_SYSTEM_FLAGS, d);
    chk(d, 8'h00);
  endtask : t_tune

  // Restore both bytes, then a write with a foreign selector is ignored
  task automatic t_restore();
    host.wr_ind(hat_pkg::SEL_SAVED_COMP_FIRST, 8'h5a);
    host.wr_ind(hat_pkg::SEL_SAVED_COMP_SECOND, 8'h02);
    host.wr_ind(8'h33, 8'hc3);
    host.rd(hat_pkg::ADDR_INDIRECT_DATA, d);
    chk(d, 8'h00);
    host.rd_ind(hat_pkg::SEL_SAVED_COMP_FIRST, d);
    chk(d, 8'h5a);
    host.rd_ind(hat_pkg::SEL_SAVED_COMP_SECOND, d);
    chk(d, 8'h02);
  endtask : t_restore

  // One turn after restore: both peaks pass, then the top term flips sign
  task automatic t_rotate();
    repeat (300) @(posedge ref_clk);
    angle(16'h0800, 16'h1000, 16'h0400, 16'h0400, 41'h00000000191);
    angle(16'h0800, 16'h0800, 16'h0800, 16'h0400, 41'h00000000000);
    angle(16'h0400, 16'h0800, 16'h0800, 16'h0400, 41'h10000000180);
    host.rd(hat_pkg::ADDR_INDIRECT_SEL, d);
    chk(d, hat_pkg::SEL_SAVED_COMP_SECOND);
    host.rd_ind(hat_pkg::SEL_SAVED_COMP_FIRST, d);
    chk(d, 8'h80);
    host.rd_ind(hat_pkg::SEL_SAVED_COMP_SECOND, d);
    chk(d, 8'h01);
  endtask : t_rotate

  // ==========================================================
  // Main sequence
  initial begin
    plateCfg[0] = '0;
    plateCfg[1] = '0;
    repeat (20) @(posedge ref_clk);
    #2;
    rstn = 1'b1;
    chk(tuneSettings[0], 18'h00000);
    t_reset();
    t_angle();
    t_tune();
    t_restore();
    t_rotate();
    complete_run();
  end
endmodule : hat_compensation_tb
